// ===== core/ees_i2c_top.sv
// Two-wire EEPROM slave: address decode, byte and page write, reads,
// coded storage and the erase/write slot timer.
// Assumes bus pins and straps are asynchronous and sampled at 20 MHz.
`timescale 1ns/100ps
// Contract
// [R1] Address byte: four type bits, three select bits high first, direction.
// [R2] Address bits arrive most significant first and are assembled so.
// [R3] Select pins read one when tied high, zero when tied low.
// [R4] Acknowledge only when select bits match own strapping.
// [R5] Hold 256 individually addressed eight-bit locations.
// [R6] Store bytes coded so any single failed bit still reads correctly.
// [R7] Internal slot timer by default, optional external timing clock.
// [R8] Byte write mode and page mode of up to eight bytes; page mode is used only for exactly eight, fewer are programmed byte by byte.
// [R9] Work at any bus clock rate down to static, no timeouts.
// [R10] Lowest address bit one means read, zero means write.
// [R11] No acknowledge to own address during an erase/write cycle.
// [R12] On mismatch release data line and ignore until next START.
module ees_i2c_top
  import ees_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE_CODE  = 4'h6, // Arbitrary value.
  parameter int        CYC_BYTE_SLOT  = BYTE_SLOT_US * CLK_MHZ,
  parameter int        CYC_PAGE_SLOT  = PAGE_SLOT_US * CLK_MHZ,
  parameter int        EXT_EDGES_SLOT = 16
) (
  input  wire logic clk_in,                 // Core clock, 20 MHz.
  input  wire logic rst_in,                 // Synchronous reset.
  input  wire logic scl_in,                 // Bus clock level.
  input  wire logic sda_in,                 // Bus data level.
  output wire logic sda_out,                // Data drive value.
  output wire logic sda_oe_out,             // Data drive enable.
  input  wire logic select_pin_low_in,      // Select strap, low bit.
  input  wire logic select_pin_mid_in,      // Select strap, middle bit.
  input  wire logic select_pin_high_in,     // Select strap, high bit.
  input  wire logic program_timing_pin_in,  // External timing clock.
  input  wire logic ext_timing_sel_in,      // High selects external time.
  output wire logic busy_out                // Erase/write cycle running.
);

  localparam logic [17:0] BYTE_LIM = 18'(CYC_BYTE_SLOT - 1);
  localparam logic [17:0] PAGE_LIM = 18'(CYC_PAGE_SLOT - 1);
  localparam logic [7:0]  EXT_LIM  = 8'(EXT_EDGES_SLOT - 1);

  logic [PIN_W-1:0] meta_q;
  logic [PIN_W-1:0] pin_q;
  logic             scl_d_q;
  logic             sda_d_q;
  logic             timing_d_q;
  logic             scl_s;
  logic             sda_s;
  logic [2:0]       sel_s;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic             timing_rise;
  ees_state_e       state_q;
  ees_state_e       next_q;
  ees_state_e       byte_next;
  logic [3:0]       bit_q;
  logic             sda_low_q;
  logic [7:0]       tx_q;
  logic [7:0]       shift_q;
  logic [7:0]       rx_byte;
  logic             byte_done;
  logic             byte_ok;
  logic             addr_hit;
  logic             waddr_done;
  logic             wdata_accept;
  logic             load_now;
  logic [3:0]       wr_cnt_q;
  logic             over_q;
  logic [7:0]       base_q;
  logic [7:0]       page_q [PAGE_BYTES];
  logic [7:0]       cur_q;
  logic [7:0]       cur_d;
  logic [7:0]       fetch_q;
  logic             busy_q;
  logic             page_mode_q;
  logic             ext_mode_q;
  logic [3:0]       slot_idx_q;
  logic [3:0]       slots_q;
  logic [17:0]      tick_q;
  logic [7:0]       edge_q;
  logic             commit;
  logic             slot_end;
  logic [3:0]       byte_idx;
  logic [7:0]       wr_addr;
  logic             mem_we;
  logic [CODE_W-1:0] mem_q [MEM_WORDS];
  ees_stream_if     rd_s ();

  // Two flip-flops on every pin before any logic looks at it.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= {PIN_W{1'b1}};
      pin_q  <= {PIN_W{1'b1}};
    end else begin
      meta_q <= {select_pin_high_in, select_pin_mid_in, select_pin_low_in,
                 ext_timing_sel_in, program_timing_pin_in, scl_in, sda_in};
      pin_q  <= meta_q;
    end
  end

  // Previous synchronised levels for edge detection. They reset to the
  // same level as the synchronisers, so no false edge follows reset.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_d_q    <= 1'b1;
      sda_d_q    <= 1'b1;
      timing_d_q <= 1'b1;
    end else begin
      scl_d_q    <= scl_s;
      sda_d_q    <= sda_s;
      timing_d_q <= pin_q[PIN_TIMING];
    end
  end

  // Strap levels are taken as plain logic levels.
  assign sel_s     = pin_q[PIN_SEL_HI:PIN_SEL_LO]; // R3
  assign scl_s     = pin_q[PIN_SCL];
  assign sda_s     = pin_q[PIN_SDA];
  assign scl_rise  = scl_s && !scl_d_q;
  assign scl_fall  = !scl_s && scl_d_q;
  assign start_det = scl_s && scl_d_q && sda_d_q && !sda_s;
  assign stop_det  = scl_s && scl_d_q && !sda_d_q && sda_s;
  assign timing_rise = pin_q[PIN_TIMING] && !timing_d_q;

  // Received bits shift in from the low end, so the first is the top bit.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift_q <= 8'h00;
    end else if (scl_rise) begin
      shift_q <= {shift_q[6:0], sda_s}; // R2
    end
  end
  assign rx_byte = {shift_q[6:0], sda_s};

  // Address decode: type code, then straps, then a busy veto.
  assign addr_hit =
    (rx_byte[ADDR_TYPE_HI:ADDR_TYPE_LO] == DEV_TYPE_CODE) && // R1
    (rx_byte[ADDR_SEL_HI:ADDR_SEL_LO] == sel_s) &&           // R4
    !busy_q;                                                 // R11

  // Whether a completed byte is acknowledged and where it leads.
  always_comb begin
    byte_ok   = 1'b1;
    byte_next = ST_WDATA;
    case (state_q)
      ST_ADDR: begin
        byte_ok   = addr_hit;
        byte_next = rx_byte[ADDR_RW] ? ST_RDATA : ST_WADDR; // R10
      end
      ST_WDATA: begin
        byte_ok = (wr_cnt_q != WCNT_PAGE); // R8
      end
      default: begin
        byte_ok   = 1'b1;
        byte_next = ST_WDATA;
      end
    endcase
  end

  assign byte_done = scl_rise && (bit_q == BIT_LAST) && !start_det &&
                     !stop_det && (state_q == ST_ADDR ||
                     state_q == ST_WADDR || state_q == ST_WDATA);
  assign waddr_done   = byte_done && (state_q == ST_WADDR);
  assign wdata_accept = byte_done && (state_q == ST_WDATA) && byte_ok;
  assign load_now     = scl_fall && !start_det && !stop_det &&
                        ((state_q == ST_ACK && sda_low_q &&
                          next_q == ST_RDATA) || state_q == ST_RNEXT);

  // Bus sequencer. It moves only on bus edges, so a stopped clock is safe.
  always_ff @(posedge clk_in) begin // R9
    if (rst_in) begin
      state_q   <= ST_IDLE;
      next_q    <= ST_IDLE;
      bit_q     <= 4'h0;
      sda_low_q <= 1'b0;
      tx_q      <= 8'h00;
    end else if (start_det) begin
      state_q   <= ST_ADDR;
      bit_q     <= 4'h0;
      sda_low_q <= 1'b0;
    end else if (stop_det) begin
      state_q   <= ST_IDLE;
      sda_low_q <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_WADDR, ST_WDATA: begin
          if (scl_rise && bit_q == BIT_LAST) begin
            bit_q <= 4'h0;
            if (byte_ok) begin
              state_q <= ST_ACK;
              next_q  <= byte_next;
            end else begin
              state_q <= ST_IGNORE; // R12
            end
          end else if (scl_rise) begin
            bit_q <= bit_q + 4'h1;
          end
        end
        ST_ACK: begin
          if (scl_fall && !sda_low_q) begin
            sda_low_q <= 1'b1; // R4
          end else if (scl_fall) begin
            state_q   <= next_q;
            sda_low_q <= 1'b0;
            if (load_now) begin
              tx_q      <= {rd_s.pop_data[6:0], 1'b0};
              sda_low_q <= ~rd_s.pop_data[7];
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise && bit_q == BIT_LAST) begin
            bit_q   <= 4'h0;
            state_q <= ST_RACK;
          end else if (scl_rise) begin
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall) begin
            sda_low_q <= ~tx_q[7];
            tx_q      <= {tx_q[6:0], 1'b0};
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            sda_low_q <= 1'b0;
          end else if (scl_rise) begin
            state_q <= sda_s ? ST_IGNORE : ST_RNEXT;
          end
        end
        ST_RNEXT: begin
          if (load_now) begin
            state_q   <= ST_RDATA;
            tx_q      <= {rd_s.pop_data[6:0], 1'b0};
            sda_low_q <= ~rd_s.pop_data[7];
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_low_q <= 1'b0; // R12
        end
        default: begin
          state_q   <= ST_IDLE;
          sda_low_q <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain data pin: only ever pulled low.
  assign sda_out    = 1'b0;
  assign sda_oe_out = sda_low_q;
  assign busy_out   = busy_q;

  // Write collection: up to a page of bytes, a ninth spoils the transfer.
  always_ff @(posedge clk_in) begin
    if (rst_in || start_det) begin
      wr_cnt_q <= 4'h0;
      over_q   <= 1'b0;
    end else if (wdata_accept) begin
      wr_cnt_q <= wr_cnt_q + 4'h1; // R8
    end else if (byte_done && state_q == ST_WDATA) begin
      over_q <= 1'b1;
    end
  end

  // Page holding bytes and the base word address.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      base_q <= 8'h00;
    end else if (waddr_done) begin
      base_q <= rx_byte;
    end
  end
  always_ff @(posedge clk_in) begin
    if (wdata_accept) begin
      page_q[wr_cnt_q[2:0]] <= rx_byte;
    end
  end

  // Current word address moves with each byte sent or taken.
  always_comb begin
    cur_d = cur_q;
    if (waddr_done) begin
      cur_d = rx_byte; // R5
    end else if (wdata_accept || (load_now && rd_s.pop_valid)) begin
      cur_d = cur_q + 8'h01;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cur_q <= 8'h00;
    end else begin
      cur_q <= cur_d;
    end
  end

  // Prefetch runs ahead of the shifter; any address move except a byte sent flushes it.
  assign rd_s.flush      = start_det || waddr_done || wdata_accept;
  assign rd_s.push_valid = !busy_q;
  assign rd_s.push_data  = ees_ecc_dec(mem_q[fetch_q]); // R6
  assign rd_s.pop_ready  = load_now;
  always_ff @(posedge clk_in) begin
    if (rst_in || rd_s.flush) begin
      fetch_q <= cur_d;
    end else if (rd_s.push_valid && rd_s.push_ready) begin
      fetch_q <= fetch_q + 8'h01;
    end
  end

  ees_stream_buf u_rd_buf (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .s      (rd_s.buf_side)
  );

  // Programming starts at STOP unless the page overflowed.
  assign commit   = stop_det && (wr_cnt_q != 4'h0) && !over_q && !busy_q;
  assign slot_end = busy_q && (ext_mode_q ?
                    (timing_rise && edge_q == EXT_LIM) : // R7
                    (tick_q == (page_mode_q ? PAGE_LIM : BYTE_LIM)));
  assign byte_idx = slot_idx_q - {3'h0, page_mode_q};
  assign mem_we   = slot_end && !(page_mode_q && slot_idx_q == 4'h0);
  assign wr_addr  = page_mode_q ?
                    {base_q[7:3], base_q[2:0] + byte_idx[2:0]} :
                    base_q + {4'h0, byte_idx};

  // Slot timer: a page spends one slot erasing, then one per byte.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_q      <= 1'b0;
      page_mode_q <= 1'b0;
      ext_mode_q  <= 1'b0;
      slot_idx_q  <= 4'h0;
      slots_q     <= 4'h0;
      tick_q      <= 18'h00000;
      edge_q      <= 8'h00;
    end else if (commit) begin
      busy_q      <= 1'b1;
      page_mode_q <= (wr_cnt_q == WCNT_PAGE); // R8
      ext_mode_q  <= pin_q[PIN_EXT];          // R7
      slot_idx_q  <= 4'h0;
      slots_q     <= wr_cnt_q + {3'h0, (wr_cnt_q == WCNT_PAGE)};
      tick_q      <= 18'h00000;
      edge_q      <= 8'h00;
    end else if (slot_end) begin
      tick_q     <= 18'h00000;
      edge_q     <= 8'h00;
      slot_idx_q <= slot_idx_q + 4'h1;
      busy_q     <= (slot_idx_q + 4'h1 != slots_q);
    end else if (busy_q) begin
      tick_q <= tick_q + 18'h00001;
      if (timing_rise) begin
        edge_q <= edge_q + 8'h01;
      end
    end
  end

  // Coded storage array, written one byte per finished slot except a page's erase slot.
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem_q[wr_addr] <= ees_ecc_enc(page_q[byte_idx[2:0]]); // R5
    end
  end

  // Checks on the bus front end and the write engine.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_type_mismatch: assert property (byte_done && state_q == ST_ADDR && // R1
    rx_byte[ADDR_TYPE_HI:ADDR_TYPE_LO] != DEV_TYPE_CODE
    |=> state_q == ST_IGNORE) else $error("type code mismatch acked");
  a_msb_first: assert property (scl_rise |=> // R2
    shift_q[0] == $past(sda_s) && shift_q[7:1] == $past(shift_q[6:0]))
    else $error("address bits not shifted msb first");
  a_sel_compare: assert property (byte_done && state_q == ST_ADDR && // R3
    rx_byte[ADDR_SEL_HI:ADDR_SEL_LO] != sel_s |=> state_q != ST_ACK)
    else $error("select bits mismatch acked");
  a_ack_drive: assert property (state_q == ST_ACK && !sda_low_q && // R4
    scl_fall && !start_det && !stop_det |=> sda_low_q ##1 sda_low_q)
    else $error("acknowledge not driven low");
  a_ecc_single: assert property (ees_ecc_dec(ees_ecc_enc(rx_byte) ^ // R6
    (12'h001 << bit_q)) == rx_byte) else $error("single bit not fixed");
  a_ext_slot: assert property (slot_end && ext_mode_q |-> timing_rise) // R7
    else $error("external slot ended without a timing edge");
  a_page_limit: assert property (wr_cnt_q <= WCNT_PAGE) // R8
    else $error("page buffer overrun");
  a_static_clk: assert property (!scl_rise && !scl_fall && !start_det && // R9
    !stop_det |=> state_q == $past(state_q))
    else $error("bus state moved without a bus edge");
  a_dir_select: assert property (byte_done && state_q == ST_ADDR && // R10
    addr_hit |=> next_q == ($past(rx_byte[ADDR_RW]) ? ST_RDATA : ST_WADDR))
    else $error("direction bit misread");
  a_busy_nack: assert property (busy_q && byte_done && // R11
    state_q == ST_ADDR |=> state_q == ST_IGNORE)
    else $error("address acked during erase write");
  a_ignore_quiet: assert property (state_q == ST_IGNORE && // R12
    !start_det |=> !sda_oe_out && state_q inside {ST_IGNORE, ST_IDLE})
    else $error("ignored transfer drove the bus");

  c_read_byte:   cover property (load_now ##[1:300] state_q == ST_RACK);
  c_page_commit: cover property (commit && wr_cnt_q == WCNT_PAGE);
  c_mismatch:    cover property (byte_done && state_q == ST_ADDR && !addr_hit);
  c_slot_write:  cover property (mem_we);

endmodule

// ===== core/ees_pkg.sv
// Shared constants, state encoding and storage code functions for the
// two-wire EEPROM slave front end.
// Assumes a 20 MHz core clock and a bus clock well below it.
package ees_pkg;

  // Core clock rate and erase/write slot lengths in their own units.
  localparam int CLK_MHZ      = 20;
  localparam int BYTE_SLOT_US = 10000;
  localparam int PAGE_SLOT_US = 3500;

  // Storage organisation.
  localparam int MEM_WORDS  = 256;
  localparam int DATA_W     = 8;
  localparam int CODE_W     = 12;
  localparam int PAGE_BYTES = 8;

  // Address byte field positions.
  localparam int ADDR_TYPE_HI = 7;
  localparam int ADDR_TYPE_LO = 4;
  localparam int ADDR_SEL_HI  = 3;
  localparam int ADDR_SEL_LO  = 1;
  localparam int ADDR_RW      = 0;

  // Bit and byte counts.
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] WCNT_PAGE = 4'h8;

  // Positions inside the synchronised pin vector.
  localparam int PIN_W      = 7;
  localparam int PIN_SDA    = 0;
  localparam int PIN_SCL    = 1;
  localparam int PIN_TIMING = 2;
  localparam int PIN_EXT    = 3;
  localparam int PIN_SEL_LO = 4;
  localparam int PIN_SEL_HI = 6;

  // Bus-side protocol states.
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WADDR,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK,
    ST_RNEXT,
    ST_IGNORE
  } ees_state_e;

  // Single-error-correcting code: data bits sit at non power-of-two
  // positions, each parity bit covers the positions holding its weight.
  function automatic logic [CODE_W-1:0] ees_ecc_enc(
    input logic [DATA_W-1:0] d
  );
    logic [CODE_W-1:0] c;
    int                k;
    c = '0;
    k = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 4; b++) begin
      for (int p = 1; p <= CODE_W; p++) begin
        if (p[b] && ((p & (p - 1)) != 0)) begin
          c[(1 << b) - 1] = c[(1 << b) - 1] ^ c[p-1];
        end
      end
    end
    return c;
  endfunction

  // The syndrome names the failed position; zero means a clean word.
  function automatic logic [DATA_W-1:0] ees_ecc_dec(
    input logic [CODE_W-1:0] code
  );
    logic [CODE_W-1:0] c;
    logic [3:0]        syn;
    logic [DATA_W-1:0] d;
    int                k;
    c   = code;
    syn = 4'h0;
    d   = '0;
    k   = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if (c[p-1]) begin
        syn = syn ^ p[3:0];
      end
    end
    if (syn != 4'h0 && int'(syn) <= CODE_W) begin
      c[syn - 4'h1] = ~c[syn - 4'h1];
    end
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = c[p-1];
        k++;
      end
    end
    return d;
  endfunction

endpackage

// ===== core/ees_stream_if.sv
// Read data stream between the storage fetch logic and the bus shifter.
// Assumes one clock domain; the buffer module receives the clock itself.
`timescale 1ns/100ps
interface ees_stream_if;
  logic       flush;
  logic       push_valid;
  logic       push_ready;
  logic [7:0] push_data;
  logic       pop_valid;
  logic       pop_ready;
  logic [7:0] pop_data;

  // The buffer side holds the storage; the user side fills and drains.
  modport buf_side (
    input  flush, push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  modport user_side (
    output flush, push_valid, push_data, pop_ready,
    input  push_ready, pop_valid, pop_data
  );
endinterface

// ===== core/ees_stream_buf.sv
// Two-entry valid/ready buffer for prefetched read bytes.
// Assumes flush is a level from the same clock domain.
`timescale 1ns/100ps
module ees_stream_buf
  import ees_pkg::*;
(
  input  wire logic clk_in,         // Core clock.
  input  wire logic rst_in,         // Synchronous reset, active high.
  ees_stream_if.buf_side s          // Push and pop sides.
);

  logic [7:0] data_q [2];
  logic       wr_q;
  logic       rd_q;
  logic [1:0] cnt_q;
  logic       push_fire;
  logic       pop_fire;

  // Full and empty follow the count, so a stalled drain stops the fill.
  assign s.push_ready = (cnt_q != 2'h2);
  assign s.pop_valid  = (cnt_q != 2'h0);
  assign s.pop_data   = data_q[rd_q];
  assign push_fire    = s.push_valid && s.push_ready && !s.flush;
  assign pop_fire     = s.pop_valid && s.pop_ready && !s.flush;

  // Pointers and count; a flush discards stale bytes after an address move.
  always_ff @(posedge clk_in) begin
    if (rst_in || s.flush) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push_fire) begin
        wr_q <= ~wr_q;
      end
      if (pop_fire) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push_fire} - {1'b0, pop_fire};
    end
  end

  // Entry storage needs no reset; the count marks what is valid.
  always_ff @(posedge clk_in) begin
    if (push_fire) begin
      data_q[wr_q] <= s.push_data;
    end
  end

endmodule

// ===== sim/ees_bus_master.sv
// Behavioural two-wire bus master that drives the clock and pulls data.
// Assumes the bench resolves the data wire with a pull-up and feeds it back.
`timescale 1ns/100ps
module ees_bus_master (
  output logic      scl_out,     // Bus clock level.
  output logic      sda_low_out, // High while the master pulls data low.
  input  wire logic sda_in       // Resolved data wire level.
);
  // Half period in ns; the bench raises it to slow the bus towards static.
  int hp = 200;

  // The bus idles with both lines released.
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // Data moves a quarter of a half period after the clock falls, so the device never
  // sees it change while the clock is still high in its synchronisers.
  task automatic bit_io(input logic b, output logic r);
    #(hp / 4) sda_low_out = !b;
    #(hp - hp / 4) scl_out = 1'b1;
    #hp r = sda_in;
    scl_out = 1'b0;
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    #(hp / 4) sda_low_out = 1'b0;
    #(hp - hp / 4) scl_out = 1'b1;
    #hp sda_low_out = 1'b1;
    #hp scl_out = 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the bus idles.
  task automatic stop();
    #(hp / 4) sda_low_out = 1'b1;
    #(hp - hp / 4) scl_out = 1'b1;
    #hp sda_low_out = 1'b0;
    #hp;
  endtask

  // One byte out, most significant bit first, then the receiver's answer.
  task automatic send8(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // One byte in with the line released, then our own answer.
  task automatic recv8(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

// ===== sim/ees_i2c_top_tb.sv
// Self-checking bench for the two-wire EEPROM slave front end.
// Assumes the shortened slot counts below and a pulled-up data wire.
`timescale 1ns/100ps
module ees_i2c_top_tb;
  localparam logic [7:0] ADR_W = 8'h6A;
  localparam logic [7:0] ADR_R = 8'h6B;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        scl, m_low, sda, sda_out, sda_oe_out, busy_out, a;
  logic [2:0]  strap = 3'h5;
  logic        prog_clk = 1'b0;
  logic        ext_sel = 1'b0;
  logic [7:0]  got [8];
  int          miscompares = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t0, n;
  // Rows: address byte, strap value, expected acknowledge.
  logic [11:0] rows [9] = '{12'h6AB, 12'h645, 12'h601, 12'h6EF, 12'h7BA,
                            12'h69A, 12'h6FA, 12'h63A, 12'h2AA};

  // The wire is low if either party pulls it; otherwise the pull-up wins.
  assign sda = !(m_low || (sda_oe_out && !sda_out));

  ees_i2c_top #(.CYC_BYTE_SLOT(400), .CYC_PAGE_SLOT(20),
    .EXT_EDGES_SLOT(2)) ees_i2c_top_i (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .select_pin_low_in(strap[0]), .select_pin_mid_in(strap[1]),
    .select_pin_high_in(strap[2]), .program_timing_pin_in(prog_clk),
    .ext_timing_sel_in(ext_sel), .busy_out(busy_out));

  ees_bus_master ees_bus_master_i (
    .scl_out(scl), .sda_low_out(m_low), .sda_in(sda));

  // Core clock, 50 ns period.
  initial begin
    forever #25 clk_in = ~clk_in;
  end

  // Timing pin runs free at 1 us; a hang is cut short by the cycle ceiling.
  always @(negedge clk_in) begin
    if (cyc % 10 == 0) prog_clk <= ~prog_clk;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end

  // Flag and byte comparisons, counted and reported at once.
  task automatic chk1(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Write n bytes from base upwards at word address wa; bytes past eight
  // must be refused.
  task automatic wr(input logic [7:0] wa, input logic [7:0] base,
                    input int n);
    ees_bus_master_i.start();
    ees_bus_master_i.send8(ADR_W, a);
    chk1(a, 1'b1);
    ees_bus_master_i.send8(wa, a);
    chk1(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      ees_bus_master_i.send8(base + i[7:0], a);
      chk1(a, i < 8);
    end
    ees_bus_master_i.stop();
    t0 = cyc;
  endtask

  // Random read of n bytes through a repeated start.
  task automatic rd(input logic [7:0] wa, input int n);
    ees_bus_master_i.start();
    ees_bus_master_i.send8(ADR_W, a);
    ees_bus_master_i.send8(wa, a);
    ees_bus_master_i.start();
    ees_bus_master_i.send8(ADR_R, a);
    chk1(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      ees_bus_master_i.recv8(got[i], i < n - 1);
    end
    ees_bus_master_i.stop();
  endtask

  // Bounded wait for the erase/write cycle to end.
  task automatic idle_wait();
    n = 0;
    while (busy_out !== 1'b0 && n < 5000) begin
      @(negedge clk_in);
      n++;
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    chk1(sda_oe_out, 1'b0);
    chk1(busy_out, 1'b0);
    repeat (4) @(negedge clk_in);
    // Address decode table; a refused device must stay deaf until START.
    foreach (rows[k]) begin
      strap = rows[k][3:1];
      repeat (4) @(negedge clk_in);
      ees_bus_master_i.start();
      ees_bus_master_i.send8(rows[k][11:4], a);
      chk1(a, rows[k][0]);
      if (!a) begin
        ees_bus_master_i.send8({4'h6, strap, 1'b1}, a);
        chk1(a, 1'b0);
      end
      ees_bus_master_i.stop();
    end
    strap = 3'h5;
    // Byte mode across the address wrap, internal timer, busy refusal.
    wr(8'hFF, 8'h5A, 2);
    chk1(busy_out, 1'b1);
    ees_bus_master_i.start();
    ees_bus_master_i.send8(ADR_R, a);
    chk1(a, 1'b0);
    ees_bus_master_i.stop();
    idle_wait();
    chk1((cyc - t0) inside {[790:810]}, 1'b1);
    rd(8'hFF, 2);
    chk8(got[0], 8'h5A);
    chk8(got[1], 8'h5B);
    // Page mode on the external timing clock; the address wraps in page.
    ext_sel = 1'b1;
    wr(8'h2E, 8'h80, 8);
    idle_wait();
    ext_sel = 1'b0;
    chk1((cyc - t0) inside {[340:385]}, 1'b1);
    rd(8'h28, 8);
    for (int j = 0; j < 8; j++) begin
      chk8(got[j], 8'h80 + 8'((j + 2) & 7));
    end
    // Nine bytes on a slow bus: refused whole, nothing programmed.
    ees_bus_master_i.hp = 1000;
    wr(8'hFF, 8'hE0, 9);
    ees_bus_master_i.hp = 200;
    repeat (4) @(negedge clk_in);
    chk1(busy_out, 1'b0);
    rd(8'hFF, 1);
    chk8(got[0], 8'h5A);
    // Current address read: the counter wrapped from the last word to 0.
    ees_bus_master_i.start();
    ees_bus_master_i.send8(ADR_R, a);
    chk1(a, 1'b1);
    ees_bus_master_i.recv8(got[0], 1'b0);
    ees_bus_master_i.stop();
    chk8(got[0], 8'h5B);
    // Reset in mid erase/write: busy drops and the device answers again.
    wr(8'h40, 8'h11, 1);
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    chk1(busy_out, 1'b0);
    chk1(sda_oe_out, 1'b0);
    repeat (4) @(negedge clk_in);
    ees_bus_master_i.start();
    ees_bus_master_i.send8(ADR_W, a);
    chk1(a, 1'b1);
    ees_bus_master_i.stop();
    conclude();
  end
endmodule
